// ### include/epm_map.svh
// offsets, field positions and reset values of the eight-bit port block
`ifndef EPM_MAP_SVH
`define EPM_MAP_SVH
// ************************************************************
// register indices, byte address is four times the index
// ************************************************************
`define EPM_DIR_IDX 20'hEE005
`define EPM_DATA_IDX 20'hFFFD5
`define EPM_CTRL_IDX 20'hEE00F
`define EPM_DIR_ADDR 32'h003B8014
`define EPM_DATA_ADDR 32'h003FFF54
`define EPM_CTRL_ADDR 32'h003B803C
// ************************************************************
// reset values and fields
// ************************************************************
`define EPM_DIR_RST 8'h80
`define EPM_DATA_RST 8'h80
`define EPM_CTRL_RST 3'h0
`define EPM_DIR_READ 8'hFF
`define EPM_CTRL_STOP_BIT 0
`define EPM_CTRL_BRLS_BIT 1
`define EPM_CTRL_STALL_BIT 2
`define EPM_PIN_CLK 7
`define EPM_PIN_GRANT 2
`define EPM_PIN_BUS_REQUEST_IN 1
`define EPM_PIN_STALL 0
`define EPM_MODE_EXP_LO 3'h1
`define EPM_MODE_EXP_HI 3'h5
`endif

// ### include/epm_pkg.sv
// types shared by the eight-bit port block
package epm_pkg;
  // strobes from the bus controller, all active low
  typedef struct packed {
    logic lwr_n;
    logic hwr_n;
    logic rd_n;
    logic as_n;
    logic back_n;
  } epm_strobe_t;
  // requests from pins towards the bus controller, active low
  typedef struct packed {
    logic bus_request_in_n;
    logic wait_n;
  } epm_bus_req_t;
  // control bits held by the block
  typedef struct packed {
    logic stall_pin_enable;
    logic bus_release_enable;
    logic clock_pin_stop;
  } epm_ctrl_t;
  typedef enum logic [1:0] {
    EPM_IDLE = 2'b01,
    EPM_ACCESS = 2'b10
  } epm_state_t;
endpackage : epm_pkg

// ### rtl/epm_port.sv
// eight-bit port with bus-strobe, bus-release, wait and clock pin sharing
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "epm_map.svh"

module epm_port
  import epm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] mode,
  input wire logic hw_standby,
  input wire logic sys_clk_level,
  input wire epm_strobe_t strobe,
  output epm_bus_req_t bus_req,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe
);

  // ************************************************************
  // registers and decode
  // ************************************************************
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] data_q;
  epm_ctrl_t ctrl_q;
  epm_state_t state_q;
  logic [31:0] prdata_q;
  logic err_q;
  logic hit_dir;
  logic hit_data;
  logic hit_ctrl;
  logic setup;
  logic wr_go;
  logic expanded;
  logic [WIDTH-1:0] data_rd;

  assign hit_dir = (paddr == `EPM_DIR_ADDR);
  assign hit_data = (paddr == `EPM_DATA_ADDR);
  assign hit_ctrl = (paddr == `EPM_CTRL_ADDR);
  assign setup = psel && !penable;
  assign wr_go = psel && penable && pwrite && pstrb[0];
  // static mode strap, modes 1 to 5 are expanded
  assign expanded = (mode >= `EPM_MODE_EXP_LO) &&
                    (mode <= `EPM_MODE_EXP_HI);

  // ************************************************************
  // apb phase tracking
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= EPM_IDLE;
    end else begin
      case (state_q)
        EPM_IDLE: begin
          if (setup) begin
            state_q <= EPM_ACCESS;
          end
        end
        EPM_ACCESS: begin
          state_q <= setup ? EPM_ACCESS : EPM_IDLE;
        end
        default: begin
          state_q <= EPM_IDLE;
        end
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && err_q;
  assign prdata = prdata_q;

  // ************************************************************
  // direction register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= `EPM_DIR_RST;
    end else if (hw_standby) begin
      dir_q <= `EPM_DIR_RST;
    end else if (wr_go && hit_dir && !err_q) begin
      // bit 7 stays one
      dir_q <= {1'b1, pwdata[WIDTH-2:0]};
    end
  end

  // ************************************************************
  // data register, bit 7 never written
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= `EPM_DATA_RST;
    end else if (hw_standby) begin
      data_q <= `EPM_DATA_RST;
    end else if (wr_go && hit_data && !err_q) begin
      data_q <= {1'b1, pwdata[WIDTH-2:0]};
    end
  end

  // ************************************************************
  // control bits: clock stop, bus release, wait enable
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `EPM_CTRL_RST;
    end else if (hw_standby) begin
      ctrl_q <= `EPM_CTRL_RST;
    end else if (wr_go && hit_ctrl && !err_q) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  // ************************************************************
  // read data, captured in the setup cycle
  // ************************************************************
  always_comb begin
    for (int i = 0; i < WIDTH - 1; i++) begin
      data_rd[i] = dir_q[i] ? data_q[i] : pin_i[i];
    end
    data_rd[WIDTH-1] = ctrl_q.clock_pin_stop ?
                       pin_i[WIDTH-1] : 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end else if (setup) begin
      err_q <= !(hit_dir || hit_data || hit_ctrl);
      if (pwrite) begin
        prdata_q <= 32'h00000000;
      end else if (hit_dir) begin
        prdata_q <= {24'h000000, `EPM_DIR_READ};
      end else if (hit_data) begin
        prdata_q <= {24'h000000, data_rd};
      end else if (hit_ctrl) begin
        prdata_q <= {29'h0, ctrl_q};
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  // ************************************************************
  // pin function select
  // ************************************************************
  always_comb begin
    // default: ports, software standby changes nothing here
    pin_o = data_q;
    pin_oe = dir_q;
    // pin 7 clock or input in every mode
    pin_o[`EPM_PIN_CLK] = sys_clk_level;
    pin_oe[`EPM_PIN_CLK] = !ctrl_q.clock_pin_stop;
    bus_req.bus_request_in_n = 1'b1;
    bus_req.wait_n = 1'b1;
    if (expanded) begin
      pin_o[6:3] = {strobe.lwr_n, strobe.hwr_n,
                    strobe.rd_n, strobe.as_n};
      pin_oe[6:3] = 4'hF;
      // pins 2 to 0 stay ports unless taken over
      if (ctrl_q.bus_release_enable) begin
        pin_o[`EPM_PIN_GRANT] = strobe.back_n;
        pin_oe[`EPM_PIN_GRANT] = 1'b1;
        pin_oe[`EPM_PIN_BUS_REQUEST_IN] = 1'b0;
        bus_req.bus_request_in_n = pin_i[`EPM_PIN_BUS_REQUEST_IN];
      end
      if (ctrl_q.stall_pin_enable) begin
        pin_oe[`EPM_PIN_STALL] = 1'b0;
        bus_req.wait_n = pin_i[`EPM_PIN_STALL];
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_dir_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    dir_q[WIDTH-1] == 1'b1)
    else $error("direction bit 7 not one");

  a_clk_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.clock_pin_stop |-> pin_oe[7] && pin_o[7] == sys_clk_level)
    else $error("pin 7 not driving clock");

  a_strobe_pins: assert property (@(posedge pclk) disable iff (!presetn)
    expanded |-> pin_oe[6:3] == 4'hF &&
    pin_o[6:3] == {strobe.lwr_n, strobe.hwr_n, strobe.rd_n, strobe.as_n})
    else $error("strobe pins not driven");

  a_single_port: assert property (@(posedge pclk) disable iff (!presetn)
    !expanded |-> pin_oe[6:0] == dir_q[6:0] && pin_o[6:0] == data_q[6:0])
    else $error("single-chip port mismatch");

  a_dir_read_ones: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_dir |=> prdata == 32'h000000FF)
    else $error("direction read not all ones");

  a_hw_standby: assert property (@(posedge pclk) disable iff (!presetn)
    hw_standby |=> dir_q == 8'h80 && data_q == 8'h80)
    else $error("standby did not reset");

  a_data_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && hit_data && !err_q && !hw_standby
    |=> data_q == {1'b1, $past(pwdata[6:0])})
    else $error("data write lost");

  a_data_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_data && !dir_q[0] |=> prdata[0] == $past(pin_i[0]))
    else $error("data read not pin level");

  a_grant_pin: assert property (@(posedge pclk) disable iff (!presetn)
    expanded && ctrl_q.bus_release_enable
    |-> pin_oe[2] && !pin_oe[1] && bus_req.bus_request_in_n == pin_i[1])
    else $error("bus release pins wrong");

  a_wait_pin: assert property (@(posedge pclk) disable iff (!presetn)
    expanded && ctrl_q.stall_pin_enable |-> !pin_oe[0])
    else $error("wait pin driven");

  a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && hit_dir && !err_q && !hw_standby
    |=> dir_q == {1'b1, $past(pwdata[6:0])})
    else $error("direction write lost");

  a_pin7_input: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.clock_pin_stop |-> !pin_oe[7])
    else $error("pin 7 driven while clock stopped");

  a_ctrl_standby: assert property (@(posedge pclk) disable iff (!presetn)
    hw_standby |=> ctrl_q == `EPM_CTRL_RST)
    else $error("standby did not clear control bits");

  a_port_low_pins: assert property (@(posedge pclk) disable iff (!presetn)
    expanded && !ctrl_q.bus_release_enable
    |-> pin_oe[2:1] == dir_q[2:1] && pin_o[2:1] == data_q[2:1])
    else $error("expanded port pins wrong");

  a_wait_port: assert property (@(posedge pclk) disable iff (!presetn)
    expanded && !ctrl_q.stall_pin_enable
    |-> pin_oe[0] == dir_q[0] && bus_req.wait_n)
    else $error("wait pin not a port");

  a_bus_request_in_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !(expanded && ctrl_q.bus_release_enable) |-> bus_req.bus_request_in_n)
    else $error("bus request seen while not released");

  a_data_bit7_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_data
    |=> prdata[7] == ($past(ctrl_q.clock_pin_stop) ?
                      $past(pin_i[7]) : 1'b1))
    else $error("data bit 7 read wrong");

  a_data_read_reg: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_data && dir_q[1]
    |=> prdata[1] == $past(data_q[1]))
    else $error("data read not stored bit");

  a_no_stray_write: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr && !hw_standby
    |=> $stable(dir_q) && $stable(data_q) && $stable(ctrl_q))
    else $error("refused access changed a register");

  a_err_in_access: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> state_q == EPM_ACCESS)
    else $error("error flag outside access phase");

  c_dir_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_go && hit_dir);
  c_release: cover property (@(posedge pclk) disable iff (!presetn)
    expanded && ctrl_q.bus_release_enable && !bus_req.bus_request_in_n);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr);
  c_clk_stop: cover property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.clock_pin_stop && setup && hit_data);
  c_wait_pin: cover property (@(posedge pclk) disable iff (!presetn)
    expanded && ctrl_q.stall_pin_enable && !bus_req.wait_n);

endmodule : epm_port

// ### verif/epm_board.sv
// board circuitry that drives the port pins the block releases
`timescale 1ns/10ps
module epm_board (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_drv,
  output logic [7:0] pin_i
);
  // released pins follow the board drive
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : ext_drv[i];
    end
  end
endmodule : epm_board

// ### verif/testbench.sv
// self-checking bench for the eight-bit shared port
`timescale 1ns/10ps
`include "epm_map.svh"
module testbench;
  import epm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rdat, rv;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, err, hw_standby = 0, sys_clk_level = 0;
  logic [2:0] mode = 3'h1, ctl_m;
  epm_strobe_t strobe = '1;
  epm_bus_req_t bus_req;
  logic [7:0] pin_i, pin_o, pin_oe, ext_drv = '0, dir_m, dat_m, eo, ev, pl;
  logic [2:0] modes [6] = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h7, 3'h0};
  int mismatches = 0, cmp_count = 0, seed = 37;
  always #10 pclk = ~pclk;
  epm_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode(mode), .hw_standby(hw_standby), .sys_clk_level(sys_clk_level),
    .strobe(strobe), .bus_req(bus_req), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe));
  epm_board board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_drv(ext_drv),
    .pin_i(pin_i));
  // ************************************************************
  // checking and bus tasks
  // ************************************************************
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    int n;
    logic hit;
    hit = a == `EPM_DIR_ADDR || a == `EPM_DATA_ADDR || a == `EPM_CTRL_ADDR;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      results();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    chk("pslverr", {31'h0, !hit}, {31'h0, err});
    if (w && hit && s[0]) begin
      if (a == `EPM_DIR_ADDR) dir_m = {1'b1, d[6:0]};
      if (a == `EPM_DATA_ADDR) dat_m[6:0] = d[6:0];
      if (a == `EPM_CTRL_ADDR) ctl_m = d[2:0];
    end
  endtask : apb
  task check_all;
    logic x;
    @(negedge pclk);
    x = mode >= 3'h1 && mode <= 3'h5;
    eo = dir_m;
    ev = dat_m;
    eo[7] = !ctl_m[0];
    ev[7] = sys_clk_level;
    if (x) begin
      eo[6:3] = 4'hF;
      ev[6:3] = {strobe.lwr_n, strobe.hwr_n, strobe.rd_n, strobe.as_n};
    end
    if (x && ctl_m[1]) begin
      eo[2:1] = 2'b10;
      ev[2] = strobe.back_n;
    end
    if (x && ctl_m[2]) eo[0] = 1'b0;
    pl = (eo & ev) | (~eo & ext_drv);
    chk("pin_oe", {24'h0, eo}, {24'h0, pin_oe});
    chk("pin_o", {24'h0, ev & eo}, {24'h0, pin_o & eo});
    chk("bus_request_in_n", {31'h0, (x && ctl_m[1]) ? ext_drv[1] : 1'b1},
      {31'h0, bus_req.bus_request_in_n});
    chk("wait_n", {31'h0, (x && ctl_m[2]) ? ext_drv[0] : 1'b1},
      {31'h0, bus_req.wait_n});
    apb(0, `EPM_DIR_ADDR, 32'h0, 4'hF);
    chk("dir read", 32'h0000_00FF, rdat);
    apb(0, `EPM_DATA_ADDR, 32'h0, 4'hF);
    chk("data read", {24'h0, ctl_m[0] ? pl[7] : 1'b1,
      (dir_m[6:0] & dat_m[6:0]) | (~dir_m[6:0] & pl[6:0])}, rdat);
    apb(0, `EPM_CTRL_ADDR, 32'h0, 4'hF);
    chk("ctrl read", {29'h0, ctl_m}, rdat);
  endtask : check_all
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    foreach (modes[m]) begin
      @(posedge pclk);
      presetn <= 0;
      mode <= modes[m];
      repeat (6) @(posedge pclk);
      presetn <= 1;
      dir_m = 8'h80;
      dat_m = 8'h80;
      ctl_m = 3'h0;
      check_all();
      for (int k = 0; k < 6; k++) begin
        rv = $random(seed);
        ext_drv <= rv[7:0];
        strobe <= rv[12:8];
        sys_clk_level <= rv[13];
        apb(1, `EPM_CTRL_ADDR, $random(seed), 4'hF);
        rv = $random(seed);
        if (ctl_m[2]) rv[0] = 1'b0;
        apb(1, `EPM_DIR_ADDR, rv, 4'hF);
        apb(1, `EPM_DATA_ADDR, $random(seed), k == 5 ? 4'hE : 4'hF);
        check_all();
      end
    end
    apb(1, 32'h0000_0010, 32'h0000_00FF, 4'hF);
    chk("unmapped data", 32'h0, rdat);
    @(posedge pclk);
    hw_standby <= 1;
    @(posedge pclk);
    hw_standby <= 0;
    dir_m = 8'h80;
    dat_m = 8'h80;
    ctl_m = 3'h0;
    check_all();
    results();
  end
endmodule : testbench
